// ### hdl/cei_map.svh
// Register offsets, field layouts, reset values and timing for the charger event masks
`ifndef CEI_MAP_SVH
`define CEI_MAP_SVH

// ============================================================
// Register offsets
`define CEI_MASK_A_ADDR   8'h29
`define CEI_MASK_B_ADDR   8'h2A
`define CEI_MASK_C_ADDR   8'h2B

// ============================================================
// Reset values and writable bits
`define CEI_MASK_RST      8'h00
`define CEI_MASK_A_WR     8'hD7
`define CEI_MASK_B_WR     8'h7F
`define CEI_MASK_C_WR     8'h1F

// ============================================================
// Edge kind per event bit: any change or rising only
`define CEI_A_ANY         8'hD3
`define CEI_A_RISE        8'h04
`define CEI_B_ANY         8'h10
`define CEI_B_RISE        8'h6F
`define CEI_C_ANY         8'h0F
`define CEI_C_RISE        8'h10
`define CEI_ADC_DONE_BIT  5

// ============================================================
// Interrupt pulse timing
`define CEI_CLK_PERIOD_NS 10
`define CEI_IRQ_PULSE_NS  1000
`define CEI_IRQ_PULSE_CYC ((`CEI_IRQ_PULSE_NS + `CEI_CLK_PERIOD_NS - 1) / `CEI_CLK_PERIOD_NS)

`endif

// ### hdl/cei_pkg.sv
// Types of the charger event interrupt mask block
package cei_pkg;

    typedef enum logic {
        CEI_IDLE,
        CEI_PULSE
    } cei_phase_t;

    typedef struct packed {
        logic [7:0] maskA;
        logic [7:0] maskB;
        logic [7:0] maskC;
        logic [7:0] prevA;
        logic [7:0] prevB;
        logic [7:0] prevC;
        logic [7:0] flagA;
        logic [7:0] flagB;
        logic [7:0] flagC;
        logic [7:0] rdData;
        logic [7:0] pulseCnt;
        cei_phase_t phase;
        logic       irqN;
    } cei_state_t;

endpackage : cei_pkg

// ### hdl/cei_charger_event_irq_masks.sv
// Charger event interrupt mask bank with interrupt pulse generator
//
// Behaviour
// RULE1: Mask A bit 7 gates the charge status change pulse; 1 blocks it.
// RULE2: Mask A bit 6 gates the input current optimiser change pulse.
// RULE3: Mask A bit 4 gates the bus supply status change pulse.
// RULE4: Mask A bit 2 gates the pulse on entering die thermal regulation only.
// RULE5: Mask A bit 1 gates the battery present change pulse.
// RULE6: Mask A bit 0 gates the charger type detection change pulse.
// RULE7: Mask B bit 6 gates the data line detection done pulse.
// RULE8: Mask B bit 5 gates the conversion done pulse, one-shot mode only.
// RULE9: Mask B bit 4 gates the pulse on entering and leaving minimum system regulation.
// RULE10: Mask B bits 3..0 gate fast, trickle, pre-charge and top-off timer expiry.
// RULE11: Mask C bit 4 gates the battery too low for OTG pulse.
// RULE12: Mask C bits 3..0 gate cold, cool, warm and hot zone crossings.
// RULE13: Mask C writable bits clear on register reset and watchdog expiry.
// RULE14: Masks A and B reset to zero, cleared only by register reset.
// RULE15: Reserved mask bits are read-only and read as zero.
// RULE16: Masked events still set their flag; masking only stops the pulse.
`timescale 1ns/1ps
`include "cei_map.svh"

module cei_charger_event_irq_masks (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrEn,
    input  wire logic [7:0] regWrData,
    output logic      [7:0] regRdData,
    input  wire logic       regResetCmd,
    input  wire logic       watchdogExpired,
    input  wire logic       adcOneShot,
    input  wire logic [7:0] eventLevelA,
    input  wire logic [7:0] eventLevelB,
    input  wire logic [7:0] eventLevelC,
    output logic      [7:0] eventFlagA,
    output logic      [7:0] eventFlagB,
    output logic      [7:0] eventFlagC,
    output logic            irq_out_n
);

    localparam int PULSE_CYC = `CEI_IRQ_PULSE_CYC;

    cei_pkg::cei_state_t st_r;
    cei_pkg::cei_state_t st_nxt;

    logic [7:0] evtA;
    logic [7:0] evtB;
    logic [7:0] evtC;
    logic       irqFire;

    // ============================================================
    // Event detection
    // Levels come from charger logic on this clock, so no synchroniser
    always_comb begin
        evtA = ((eventLevelA ^ st_r.prevA) & `CEI_A_ANY)
             | ((eventLevelA & ~st_r.prevA) & `CEI_A_RISE);    // RULE4
        evtB = ((eventLevelB ^ st_r.prevB) & `CEI_B_ANY)       // RULE9
             | ((eventLevelB & ~st_r.prevB) & `CEI_B_RISE);    // RULE10
        // Conversion done only counts while converting one-shot
        if (!adcOneShot) begin
            evtB[`CEI_ADC_DONE_BIT] = 1'b0;                    // RULE8
        end
        evtC = ((eventLevelC ^ st_r.prevC) & `CEI_C_ANY)       // RULE12
             | ((eventLevelC & ~st_r.prevC) & `CEI_C_RISE);    // RULE11
        // A set bit in a mask suppresses only the pulse
        irqFire = |(evtA & ~st_r.maskA)                        // RULE1 RULE2 RULE3 RULE5 RULE6
                | |(evtB & ~st_r.maskB)                        // RULE7
                | |(evtC & ~st_r.maskC);
    end

    // ============================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.prevA = eventLevelA;
        st_nxt.prevB = eventLevelB;
        st_nxt.prevC = eventLevelC;
        // Flag strobes ignore the masks so status still records masked events
        st_nxt.flagA = evtA;                                   // RULE16
        st_nxt.flagB = evtB;                                   // RULE16
        st_nxt.flagC = evtC;                                   // RULE16

        // Register write; reserved bits never stored
        if (regWrEn) begin
            case (regAddr)
                `CEI_MASK_A_ADDR: st_nxt.maskA = regWrData & `CEI_MASK_A_WR;   // RULE15
                `CEI_MASK_B_ADDR: st_nxt.maskB = regWrData & `CEI_MASK_B_WR;   // RULE15
                `CEI_MASK_C_ADDR: st_nxt.maskC = regWrData & `CEI_MASK_C_WR;   // RULE15
                default: ;
            endcase
        end
        // Clears beat a write in the same cycle
        if (watchdogExpired) begin
            st_nxt.maskC = `CEI_MASK_RST;                      // RULE13
        end
        if (regResetCmd) begin
            st_nxt.maskA = `CEI_MASK_RST;                      // RULE14
            st_nxt.maskB = `CEI_MASK_RST;                      // RULE14
            st_nxt.maskC = `CEI_MASK_RST;                      // RULE13
        end

        // Read data shows the stored masks, zero elsewhere
        case (regAddr)
            `CEI_MASK_A_ADDR: st_nxt.rdData = st_r.maskA;
            `CEI_MASK_B_ADDR: st_nxt.rdData = st_r.maskB;
            `CEI_MASK_C_ADDR: st_nxt.rdData = st_r.maskC;
            default:          st_nxt.rdData = 8'h00;
        endcase

        // Pulse generator; a new unmasked event restarts the full low time
        case (st_r.phase)
            cei_pkg::CEI_IDLE: begin
                st_nxt.irqN = 1'b1;
                if (irqFire) begin
                    st_nxt.phase    = cei_pkg::CEI_PULSE;
                    st_nxt.pulseCnt = 8'(PULSE_CYC - 1);
                    st_nxt.irqN     = 1'b0;
                end
            end
            cei_pkg::CEI_PULSE: begin
                st_nxt.irqN = 1'b0;
                if (irqFire) begin
                    st_nxt.pulseCnt = 8'(PULSE_CYC - 1);
                end else if (st_r.pulseCnt == 8'h00) begin
                    st_nxt.phase = cei_pkg::CEI_IDLE;
                    st_nxt.irqN  = 1'b1;
                end else begin
                    st_nxt.pulseCnt = st_r.pulseCnt - 8'h01;
                end
            end
            default: begin
                st_nxt.phase = cei_pkg::CEI_IDLE;
                st_nxt.irqN  = 1'b1;
            end
        endcase
    end

    // ============================================================
    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r.maskA    <= `CEI_MASK_RST;
            st_r.maskB    <= `CEI_MASK_RST;
            st_r.maskC    <= `CEI_MASK_RST;
            st_r.prevA    <= 8'h00;
            st_r.prevB    <= 8'h00;
            st_r.prevC    <= 8'h00;
            st_r.flagA    <= 8'h00;
            st_r.flagB    <= 8'h00;
            st_r.flagC    <= 8'h00;
            st_r.rdData   <= 8'h00;
            st_r.pulseCnt <= 8'h00;
            st_r.phase    <= cei_pkg::CEI_IDLE;
            st_r.irqN     <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdData  = st_r.rdData;
    assign eventFlagA = st_r.flagA;
    assign eventFlagB = st_r.flagB;
    assign eventFlagC = st_r.flagC;
    assign irq_out_n  = st_r.irqN;

    // ============================================================
    // Assertions
    // Low-time counter of the interrupt line, for the pulse width checks
    logic [7:0] lowCnt;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lowCnt <= 8'h00;
        end else if (irq_out_n) begin
            lowCnt <= 8'h00;
        end else begin
            lowCnt <= lowCnt + 8'h01;
        end
    end

    a_chg_status_gate: assert property (@(posedge clk) disable iff (!nrst) // RULE1
        (st_r.phase == cei_pkg::CEI_IDLE && evtA == 8'h80 && evtB == 8'h00 && evtC == 8'h00)
        |=> (irq_out_n == $past(st_r.maskA[7])))
        else $error("charge status pulse does not follow its mask");

    a_ico_gate: assert property (@(posedge clk) disable iff (!nrst) // RULE2
        (evtA[6] && !st_r.maskA[6]) |=> !irq_out_n)
        else $error("optimiser change with mask clear gave no pulse");

    a_bus_masked: assert property (@(posedge clk) disable iff (!nrst) // RULE3
        (st_r.phase == cei_pkg::CEI_IDLE && evtA == 8'h10 && st_r.maskA[4] && evtB == 8'h00 && evtC == 8'h00)
        |=> irq_out_n)
        else $error("masked bus supply change still pulsed");

    a_die_thermal_regulation_rise_only: assert property (@(posedge clk) disable iff (!nrst) // RULE4
        ($fell(eventLevelA[2])) |-> !evtA[2])
        else $error("leaving thermal regulation raised an event");

    a_timer_gate: assert property (@(posedge clk) disable iff (!nrst) // RULE10
        (|(evtB[3:0] & ~st_r.maskB[3:0])) |=> !irq_out_n)
        else $error("unmasked timer expiry gave no pulse");

    a_adc_oneshot: assert property (@(posedge clk) disable iff (!nrst) // RULE8
        (!adcOneShot) |-> !evtB[5])
        else $error("conversion done seen outside one-shot mode");

    a_wdog_clears_c: assert property (@(posedge clk) disable iff (!nrst) // RULE13
        watchdogExpired |=> (st_r.maskC == 8'h00))
        else $error("watchdog left third mask set");

    a_wdog_keeps_ab: assert property (@(posedge clk) disable iff (!nrst) // RULE14
        (watchdogExpired && !regResetCmd && !regWrEn) |=> $stable(st_r.maskA) && $stable(st_r.maskB))
        else $error("watchdog disturbed first or second mask");

    a_reserved_zero: assert property (@(posedge clk) disable iff (!nrst) // RULE15
        (st_r.maskA[5] == 1'b0 && st_r.maskA[3] == 1'b0 && st_r.maskB[7] == 1'b0 && st_r.maskC[7:5] == 3'h0))
        else $error("reserved mask bit became set");

    a_flag_unmasked: assert property (@(posedge clk) disable iff (!nrst) // RULE16
        (|evtC) |=> (eventFlagC == $past(evtC)))
        else $error("event did not reach its flag strobe");

    a_pulse_width: assert property (@(posedge clk) disable iff (!nrst) // interrupt pulse timing
        $rose(irq_out_n) |-> (lowCnt >= 8'(PULSE_CYC)))
        else $error("interrupt pulse shorter than its time");

    // Per-event gates: an unmasked event must start or extend the low time
    a_batt_present_gate: assert property (@(posedge clk) disable iff (!nrst) // RULE5
        (evtA[1] && !st_r.maskA[1]) |=> !irq_out_n)
        else $error("battery present change with mask clear gave no pulse");

    a_type_detect_gate: assert property (@(posedge clk) disable iff (!nrst) // RULE6
        (evtA[0] && !st_r.maskA[0]) |=> !irq_out_n)
        else $error("charger type change with mask clear gave no pulse");

    a_die_thermal_regulation_gate: assert property (@(posedge clk) disable iff (!nrst) // RULE4
        (evtA[2] && !st_r.maskA[2]) |=> !irq_out_n)
        else $error("thermal regulation entry with mask clear gave no pulse");

    a_line_detect_gate: assert property (@(posedge clk) disable iff (!nrst) // RULE7
        (evtB[6] && !st_r.maskB[6]) |=> !irq_out_n)
        else $error("data line detection done with mask clear gave no pulse");

    a_adc_done_gate: assert property (@(posedge clk) disable iff (!nrst) // RULE8
        (evtB[5] && !st_r.maskB[5]) |=> !irq_out_n)
        else $error("conversion done with mask clear gave no pulse");

    a_min_sys_gate: assert property (@(posedge clk) disable iff (!nrst) // RULE9
        (evtB[4] && !st_r.maskB[4]) |=> !irq_out_n)
        else $error("minimum system regulation change with mask clear gave no pulse");

    a_otg_low_gate: assert property (@(posedge clk) disable iff (!nrst) // RULE11
        (evtC[4] && !st_r.maskC[4]) |=> !irq_out_n)
        else $error("low battery for OTG with mask clear gave no pulse");

    a_zone_gate: assert property (@(posedge clk) disable iff (!nrst) // RULE12
        (|(evtC[3:0] & ~st_r.maskC[3:0])) |=> !irq_out_n)
        else $error("zone crossing with mask clear gave no pulse");

    // Edge kinds against the level history; the first edge after release is skipped
    // because the history restarts from zero there
    a_min_sys_both: assert property (@(posedge clk) disable iff (!nrst) // RULE9
        $past(nrst) |-> (evtB[4] == (eventLevelB[4] ^ $past(eventLevelB[4]))))
        else $error("minimum system regulation edge not seen as event");

    a_zone_both: assert property (@(posedge clk) disable iff (!nrst) // RULE12
        $past(nrst) |-> (evtC[3:0] == (eventLevelC[3:0] ^ $past(eventLevelC[3:0]))))
        else $error("zone crossing edge not seen as event");

    a_otg_low_rise: assert property (@(posedge clk) disable iff (!nrst) // RULE11
        $fell(eventLevelC[4]) |-> !evtC[4])
        else $error("recovery from low battery for OTG raised an event");

    a_regrst_clears: assert property (@(posedge clk) disable iff (!nrst) // RULE14
        regResetCmd |=> (st_r.maskA == 8'h00 && st_r.maskB == 8'h00 && st_r.maskC == 8'h00))
        else $error("register reset left a mask set");

    // Nothing unmasked in idle must leave the line high, masked events included
    a_masked_quiet: assert property (@(posedge clk) disable iff (!nrst) // RULE16
        (st_r.phase == cei_pkg::CEI_IDLE && (evtA & ~st_r.maskA) == 8'h00
         && (evtB & ~st_r.maskB) == 8'h00 && (evtC & ~st_r.maskC) == 8'h00) |=> irq_out_n)
        else $error("masked or absent event pulsed the interrupt line");

    a_flags_ab: assert property (@(posedge clk) disable iff (!nrst) // RULE16
        ((|evtA) || (|evtB)) |=> (eventFlagA == $past(evtA) && eventFlagB == $past(evtB)))
        else $error("event did not reach its first or second flag strobe");

    // ============================================================
    // Cover points
    c_masked_event: cover property (@(posedge clk) disable iff (!nrst)
        (|(evtA & st_r.maskA)) && !irqFire);
    c_full_pulse: cover property (@(posedge clk) disable iff (!nrst)
        $rose(irq_out_n));
    c_wdog_clear: cover property (@(posedge clk) disable iff (!nrst)
        watchdogExpired && (st_r.maskC != 8'h00));
    c_pulse_restart: cover property (@(posedge clk) disable iff (!nrst)
        st_r.phase == cei_pkg::CEI_PULSE && irqFire);
    c_adc_ignored: cover property (@(posedge clk) disable iff (!nrst)
        !adcOneShot && eventLevelB[5] && !st_r.prevB[5]);

endmodule : cei_charger_event_irq_masks

// ### sim/cei_host_model.sv
// Behavioural host that counts pulses on the active-low interrupt line
`timescale 1ns/1ps

module cei_host_model (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic irq_out_n,
    output int        pulseCount
);
    logic irqSeen_r;

    // Falling edges only: a restarted pulse is still one pulse
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irqSeen_r  <= 1'b1;
            pulseCount <= 0;
        end else begin
            irqSeen_r <= irq_out_n;
            if (irqSeen_r && !irq_out_n) begin
                pulseCount <= pulseCount + 1;
            end
        end
    end
endmodule : cei_host_model

// ### sim/test_cei_charger_event_irq_masks.sv
// Self-checking testbench of the charger event interrupt mask bank
`timescale 1ns/1ps
`include "cei_map.svh"

module test_cei_charger_event_irq_masks;
    logic       clk;
    logic       nrst;
    logic [7:0] regAddr;
    logic       regWrEn;
    logic [7:0] regWrData;
    logic [7:0] regRdData;
    logic       regResetCmd;
    logic       watchdogExpired;
    logic       adcOneShot;
    logic [7:0] ev [3];
    logic [7:0] flag [3];
    logic       irq_out_n;
    logic       rdPend;
    logic       rdLate;
    int         pulseCount;
    int         n_errors;
    int         num_checks;
    int         expPulses;
    logic [7:0] expQ [$];
    logic [23:0] flagQ [$];
    logic [7:0] wrMask [3];
    logic [7:0] anyMask [3];
    logic [7:0] mask [3];

    cei_charger_event_irq_masks i_dut (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdData(regRdData), .regResetCmd(regResetCmd),
        .watchdogExpired(watchdogExpired), .adcOneShot(adcOneShot), .eventLevelA(ev[0]),
        .eventLevelB(ev[1]), .eventLevelC(ev[2]), .eventFlagA(flag[0]), .eventFlagB(flag[1]),
        .eventFlagC(flag[2]), .irq_out_n(irq_out_n));
    cei_host_model i_host (.clk(clk), .nrst(nrst), .irq_out_n(irq_out_n), .pulseCount(pulseCount));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ============================================================
    // Tasks
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_read(input logic [7:0] exp, input logic [7:0] got);
        chk("regRdData", 24'(exp), 24'(got));
    endtask : chk_read

    task automatic chk_flag(input logic [23:0] exp, input logic [23:0] got);
        chk("eventFlag", exp, got);
    endtask : chk_flag

    task automatic chk_irq(input logic exp, input logic got);
        chk("irq_out_n", 24'(exp), 24'(got));
    endtask : chk_irq

    task automatic chk_count(input string what, input int exp, input int got);
        chk(what, 24'(exp), 24'(got));
    endtask : chk_count

    task automatic cyc();
        @(posedge clk);
        #1;
    endtask : cyc

    // Extra idle cycle keeps strobes from being driven twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr   = a;
        regWrData = d;
        regWrEn   = 1'b1;
        cyc();
        regWrEn = 1'b0;
        cyc();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        regAddr = a;
        rdPend  = 1'b1;
        expQ.push_back(e);
        cyc();
        rdPend = 1'b0;
        cyc();
    endtask : rd

    task automatic finish_test();
        if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    // ============================================================
    // Read monitor: data is registered one edge after the address
    always @(posedge clk) rdLate <= rdPend;
    always @(negedge clk) begin
        if (rdLate === 1'b1) chk_read(expQ.pop_front(), regRdData);
    end

    // Every flag pulse must have been announced; an unannounced one is a mismatch
    always @(negedge clk) begin
        if (nrst === 1'b1 && {flag[0], flag[1], flag[2]} !== 24'h000000) begin
            if (flagQ.size() == 0) chk_flag(24'h000000, {flag[0], flag[1], flag[2]});
            else chk_flag(flagQ.pop_front(), {flag[0], flag[1], flag[2]});
        end
    end

    initial begin
        #200000;
        n_errors++;
        finish_test();
    end

    // ============================================================
    // Main sequence
    initial begin
        nrst = 1'b0;
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regResetCmd = 1'b0;
        watchdogExpired = 1'b0;
        adcOneShot = 1'b1;
        rdPend = 1'b0;
        ev = '{8'h00, 8'h00, 8'h00};
        n_errors = 0;
        num_checks = 0;
        expPulses = 0;
        wrMask = '{`CEI_MASK_A_WR, `CEI_MASK_B_WR, `CEI_MASK_C_WR};
        anyMask = '{`CEI_A_ANY, `CEI_B_ANY, `CEI_C_ANY};
        void'($urandom(96));
        repeat (3) @(posedge clk);
        #1 nrst = 1'b1;
        cyc();
        for (int r = 0; r < 3; r++) rd(8'(`CEI_MASK_A_ADDR + r), `CEI_MASK_RST);
        rd(8'h28, 8'h00);
        for (int r = 0; r < 3; r++) begin
            wr(8'(`CEI_MASK_A_ADDR + r), 8'hFF);
            rd(8'(`CEI_MASK_A_ADDR + r), wrMask[r]);
        end
        wr(8'h2C, 8'hFF);
        rd(8'h2C, 8'h00);
        watchdogExpired = 1'b1;
        cyc();
        watchdogExpired = 1'b0;
        cyc();
        for (int r = 0; r < 3; r++) rd(8'(`CEI_MASK_A_ADDR + r), (r == 2) ? 8'h00 : wrMask[r]);
        regResetCmd = 1'b1;
        cyc();
        regResetCmd = 1'b0;
        cyc();
        for (int r = 0; r < 3; r++) rd(8'(`CEI_MASK_A_ADDR + r), 8'h00);
        // Second pass inverts the masks so every event is seen masked and unmasked
        for (int p = 0; p < 2; p++) begin
            for (int r = 0; r < 3; r++) begin
                mask[r] = (p == 0) ? (8'($urandom) & wrMask[r]) : (~mask[r] & wrMask[r]);
                wr(8'(`CEI_MASK_A_ADDR + r), mask[r]);
                rd(8'(`CEI_MASK_A_ADDR + r), mask[r]);
            end
            for (int r = 0; r < 3; r++) begin
                for (int b = 0; b < 8; b++) begin
                    if (wrMask[r][b]) begin
                        flagQ.push_back(24'h000001 << (8 * (2 - r) + b));
                        ev[r][b] = 1'b1;
                        cyc();
                        chk_irq(mask[r][b], irq_out_n);
                        expPulses += !mask[r][b];
                        repeat (110) cyc();
                        chk_count("pulseCount", expPulses, pulseCount);
                        if (anyMask[r][b]) flagQ.push_back(24'h000001 << (8 * (2 - r) + b));
                        ev[r][b] = 1'b0;
                        cyc();
                        expPulses += anyMask[r][b] && !mask[r][b];
                        repeat (110) cyc();
                        chk_count("pulseCount", expPulses, pulseCount);
                    end
                end
            end
        end
        // Register reset clears every mask, so the cases below run unmasked
        regResetCmd = 1'b1;
        cyc();
        regResetCmd = 1'b0;
        cyc();
        // Conversion done outside one-shot mode: no flag, no pulse
        adcOneShot = 1'b0;
        ev[1][5] = 1'b1;
        cyc();
        chk_irq(1'b1, irq_out_n);
        repeat (110) cyc();
        ev[1][5] = 1'b0;
        cyc();
        adcOneShot = 1'b1;
        chk_count("pulseCount", expPulses, pulseCount);
        // A second event inside the pulse stretches it into one longer pulse
        flagQ.push_back(24'h800000);
        ev[0][7] = 1'b1;
        cyc();
        expPulses++;
        repeat (50) cyc();
        flagQ.push_back(24'h800000);
        ev[0][7] = 1'b0;
        repeat (81) cyc();
        chk_irq(1'b0, irq_out_n);
        repeat (40) cyc();
        chk_irq(1'b1, irq_out_n);
        chk_count("pulseCount", expPulses, pulseCount);
        chk_count("flagQueue", 0, flagQ.size());
        finish_test();
    end
endmodule : test_cei_charger_event_irq_masks
